//--- dv/ebsc_bus_partner.sv
/*
 * Far-side model: memory acknowledge with wait states, outside masters
 * and resolution of the shared pins.
 * Assumes pin enables are low while the strobe control drives.
 */
`default_nettype none
module ebsc_bus_partner (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [1:0] waitCycles,  // Wait states per word
    input  wire logic       extRdN,      // Outside master read strobe
    input  wire logic       extWrN,      // Outside master write strobe
    input  wire logic       rdNOut,
    input  wire logic       rdOeN,
    input  wire logic       wrNOut,
    input  wire logic       wrOeN,
    input  wire logic       burstIndicatorOut,
    input  wire logic       burstIndicatorOeN,
    input  wire logic       ackOut,
    input  wire logic       ackOeN,
    output logic            rdNIn,
    output logic            wrNIn,
    output logic            burstIndicatorIn,
    output logic            ackIn
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_q, cnt_d;            // Wait cycles spent on this word
    logic [7:0] offset_q, offset_d;      // Burst slave's own address offset
    logic       strobeLow, memAck;
    // Memory holds ack low for waitCycles cycles per word
    always_comb begin
        strobeLow = (!rdOeN && !rdNOut) || (!wrOeN && !wrNOut);
        memAck    = !(strobeLow && cnt_q != waitCycles);
        cnt_d     = (strobeLow && !memAck) ? cnt_q + 2'h1 : 2'h0;
        // Address not on the bus: count acknowledged words while strobed
        offset_d  = strobeLow ? offset_q + 8'(memAck) : 8'h00;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt_q    <= 2'h0;
            offset_q <= 8'h00;
        end else begin
            cnt_q    <= cnt_d;
            offset_q <= offset_d;
        end
    end
    // Released pins: strobes from the outside master, ack from memory, burst pulled down
    assign rdNIn = rdOeN ? extRdN : rdNOut;
    assign wrNIn = wrOeN ? extWrN : wrNOut;
    assign burstIndicatorIn = burstIndicatorOeN ? 1'b0 : burstIndicatorOut;
    assign ackIn = ackOeN ? memAck : ackOut;
endmodule
`default_nettype wire

//--- dv/external_bus_strobe_control_bench.sv
/*
 * Self-checking bench of the strobe control with random accesses.
 * Assumes ebsc_pkg, the carrier and all design modules are compiled.
 */
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module external_bus_strobe_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rstn, reqValid, reqWrite, reqReady, doneP, busMaster, iopBusy;
    logic iopReadP, iopWriteP, sdCmdValid, sdAddrTen, rdNIn, rdNOut, rdOeN;
    logic wrNIn, wrNOut, wrOeN, burstIndicatorIn, burstIndicatorOut;
    logic burstIndicatorOeN, burstKeepLevel, ackIn, ackOut, ackOeN;
    logic suspendTristateN, rowStrobeN, colStrobeN, sdramWriteEnableN;
    logic memorySelectN, sdramAddrBitTen, sdramOeN, extRdN, extWrN;
    logic [7:0] reqLen;
    logic [2:0] processorIdentityInputs;
    logic [1:0] waitCycles;
    ebsc_pkg::ebsc_sdcmd_t sdCmd;
    int err_total, checks;
    ebsc_strobe_ctrl u_ebsc_strobe_ctrl (.clk_sys, .rstn, .reqValid, .reqWrite,
        .reqLen, .reqReady, .doneP, .busMaster, .processorIdentityInputs, .iopBusy,
        .iopReadP, .iopWriteP, .sdCmdValid, .sdCmd, .sdAddrTen, .rdNIn, .rdNOut,
        .rdOeN, .wrNIn, .wrNOut, .wrOeN, .burstIndicatorIn, .burstIndicatorOut,
        .burstIndicatorOeN, .burstKeepLevel, .ackIn, .ackOut, .ackOeN,
        .suspendTristateN, .rowStrobeN, .colStrobeN, .sdramWriteEnableN,
        .memorySelectN, .sdramAddrBitTen, .sdramOeN);
    ebsc_bus_partner u_ebsc_bus_partner (.clk_sys, .rstn, .waitCycles, .extRdN,
        .extWrN, .rdNOut, .rdOeN, .wrNOut, .wrOeN, .burstIndicatorOut,
        .burstIndicatorOeN, .ackOut, .ackOeN, .rdNIn, .wrNIn, .burstIndicatorIn,
        .ackIn);
    // ****************************************
    // Clock, verdict, expectations
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // SDRAM pin code {ras,cas,we} per command
    function automatic logic [2:0] sd_exp(input int c);
        case (c)
            1: return ebsc_pkg::SD_PINS_ACT;
            2: return ebsc_pkg::SD_PINS_RD;
            3: return ebsc_pkg::SD_PINS_WR;
            4: return ebsc_pkg::SD_PINS_PRE;
            5: return ebsc_pkg::SD_PINS_REF;
            default: return ebsc_pkg::SD_PINS_MRS;
        endcase
    endfunction
    // Bounded wait for doneP; counts bus strobe, burst and keeper cycles
    task automatic wait_done(input logic wr, output int n, output int nb, output int nk);
        int k;
        n = 0;
        nb = 0;
        nk = 0;
        k = 0;
        while (doneP !== 1'b1 && k < 300) begin
            @(negedge clk_sys);
            if ((wr ? wrNIn : rdNIn) === 1'b0 && doneP !== 1'b1) n++;
            if (burstIndicatorOut === 1'b1) nb++;
            if (burstKeepLevel === 1'b1) nk++;
            k++;
        end
        if (k >= 300) begin
            err_total++;
            stop_test();
        end
    endtask
    // One access of len words against a memory with w wait states
    task automatic access(input logic wr, input logic [7:0] len, input int w);
        int n, nb, nk, words;
        words = (len == 8'h00) ? 1 : int'(len);
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqLen <= len;
        waitCycles <= 2'(w);
        @(posedge clk_sys);
        reqValid <= 1'b0;
        wait_done(wr, n, nb, nk);
        `CHK("strobe cycles", words * (w + 1), n)
        `CHK("burst cycles", (words > 2) ? (words - 2) * (w + 1) : 0, nb)
        `CHK("keeper cycles", (words > 2) ? (words - 2) * (w + 1) : 0, nk)
        `CHK("slave offset", words, u_ebsc_bus_partner.offset_q)
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rstn, reqValid, reqWrite, sdCmdValid, sdAddrTen, iopBusy} = '0;
        {busMaster, suspendTristateN, extRdN, extWrN} = 4'hf;
        {reqLen, processorIdentityInputs, waitCycles} = '0;
        sdCmd = ebsc_pkg::EBSC_SD_NOP;
        err_total = 0;
        checks = 0;
        void'($urandom(32'hc92d));
        repeat (12) @(posedge clk_sys);
        `CHK("reset pins", 4'hf, {rdNOut, rdOeN, memorySelectN, rowStrobeN})
        rstn <= 1'b1;
        // Release lands after this edge's flops; the first live edge is the next
        repeat (2) @(negedge clk_sys);
        `CHK("master drives", 1'b0, rdOeN)
        access(1'b0, 8'h00, 0);
        access(1'b1, 8'h01, 0);
        access(1'b0, 8'h04, 2);
        repeat (14) access(1'($urandom % 2), 8'($urandom % 6), $urandom % 3);
        // Access attempted while suspended halts and floats, then resumes
        @(posedge clk_sys);
        suspendTristateN <= 1'b0;
        fork
            access(1'b0, 8'h03, 0);
            begin
                repeat (3) @(negedge clk_sys);
                `CHK("suspend float", 3'h7, {rdOeN, wrOeN, sdramOeN})
                repeat (4) begin
                    @(negedge clk_sys);
                    `CHK("halted", 1'b0, doneP)
                end
                @(posedge clk_sys);
                suspendTristateN <= 1'b1;
            end
        join
        // Slave: outside strobes seen, own register waits on ack
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            {busMaster, iopBusy} <= 2'h1;
            {extRdN, extWrN} <= i ? 2'h1 : 2'h2;
            @(negedge clk_sys);
            `CHK("slave ready", 1'b0, reqReady)
            // Own drive lingers one cycle before the pins are released
            @(negedge clk_sys);
            `CHK("slave strobe", i ? 2'h2 : 2'h1, {iopReadP, iopWriteP})
            @(negedge clk_sys);
            `CHK("ack pulled low", 3'h1, {ackOeN, ackIn, rdOeN})
            @(posedge clk_sys);
            {busMaster, iopBusy, extRdN, extWrN} <= 4'hb;
        end
        // SDRAM commands in turn
        for (int c = 1; c < 7; c++) begin
            @(posedge clk_sys);
            sdCmdValid <= 1'b1;
            sdCmd <= ebsc_pkg::ebsc_sdcmd_t'(c);
            sdAddrTen <= 1'($urandom);
            @(posedge clk_sys);
            sdCmdValid <= 1'b0;
            @(negedge clk_sys);
            `CHK("sdram cmd", {sd_exp(c), 1'b0, sdAddrTen}, {rowStrobeN, colStrobeN,
                sdramWriteEnableN, memorySelectN, sdramAddrBitTen})
            @(negedge clk_sys);
            `CHK("sdram nop", 4'hf, {rowStrobeN, colStrobeN, sdramWriteEnableN,
                memorySelectN})
        end
        stop_test();
    end
endmodule
`undef CHK
`default_nettype wire

//--- include/ebsc_pkg.sv
/*
 * Shared constants and types of the external bus strobe control block.
 * Assumes nothing beyond a SystemVerilog compiler; used with ebsc_pkg:: scope.
 */
`default_nettype none
package ebsc_pkg;
    // ****************************************
    // Widths and reset levels
    // ****************************************
    localparam int LEN_W = 8;                 // Burst length counter width
    localparam int ID_W  = 3;                 // Identity input width
    localparam logic STROBE_IDLE = 1'b1;      // Strobes rest high
    localparam logic OE_OFF      = 1'b1;      // Output enable low = drive
    localparam logic BURST_IDLE  = 1'b0;      // Burst indicator rest level
    localparam logic [LEN_W-1:0] LEN_ZERO = 8'h00;
    localparam logic [LEN_W-1:0] LEN_ONE  = 8'h01;
    // Keeper enabled for identity 00x
    localparam logic [ID_W-1:0] ID_KEEP_MASK = 3'h6;
    localparam logic [ID_W-1:0] ID_KEEP_VAL  = 3'h0;

    // ****************************************
    // Access state machine, Gray coded
    // ****************************************
    typedef enum logic [1:0] {
        EBSC_IDLE = 2'h0,                     // No access
        EBSC_XFER = 2'h1,                     // Strobe out, waiting on ack
        EBSC_HALT = 2'h3                      // Suspended mid access
    } ebsc_state_t;

    // ****************************************
    // SDRAM commands and pin codes {ras,cas,we}
    // ****************************************
    typedef enum logic [2:0] {
        EBSC_SD_NOP = 3'h0,
        EBSC_SD_ACT = 3'h1,
        EBSC_SD_RD  = 3'h2,
        EBSC_SD_WR  = 3'h3,
        EBSC_SD_PRE = 3'h4,
        EBSC_SD_REF = 3'h5,
        EBSC_SD_MRS = 3'h6
    } ebsc_sdcmd_t;
    localparam logic [2:0] SD_PINS_NOP = 3'h7;
    localparam logic [2:0] SD_PINS_ACT = 3'h3;
    localparam logic [2:0] SD_PINS_RD  = 3'h5;
    localparam logic [2:0] SD_PINS_WR  = 3'h4;
    localparam logic [2:0] SD_PINS_PRE = 3'h2;
    localparam logic [2:0] SD_PINS_REF = 3'h1;
    localparam logic [2:0] SD_PINS_MRS = 3'h0;
endpackage
`default_nettype wire

//--- include/ebsc_sdram_if.sv
/*
 * Carrier between the strobe control top and its SDRAM command encoder.
 * Assumes ebsc_pkg is compiled first.
 */
`default_nettype none
interface ebsc_sdram_if;
    logic                 cmdValid;      // Command issue pulse
    ebsc_pkg::ebsc_sdcmd_t cmd;          // Command to encode
    logic                 addrTen;       // Requested address bit ten
    logic                 rowStrobeN;    // Encoded row strobe
    logic                 colStrobeN;    // Encoded column strobe
    logic                 writeEnableN;  // Encoded SDRAM write enable
    logic                 selectN;       // Encoded select
    logic                 bitTen;        // Encoded address bit ten
    modport enc (input cmdValid, cmd, addrTen,
                 output rowStrobeN, colStrobeN, writeEnableN, selectN, bitTen);
    modport ctl (output cmdValid, cmd, addrTen,
                 input rowStrobeN, colStrobeN, writeEnableN, selectN, bitTen);
endinterface
`default_nettype wire

//--- verilog/ebsc_keeper.sv
/*
 * Hold circuit for one bus pin: remembers the last driven level.
 * Assumes pin input synchronous to clk_sys.
 */
`default_nettype none
module ebsc_keeper #(
    parameter logic RST_LEVEL = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic keepEn,     // Hold circuit enabled
    input  wire logic pinIn,      // Level seen on the pin
    input  wire logic ownOeN,     // Own driver enable, low drives
    input  wire logic ownOut,     // Own driven level
    output logic      keepLevel   // Level the hold circuit presents
);
    logic level_q;                // Last driven level
    logic level_d;

    // ****************************************
    // Next level
    // ****************************************
    always_comb begin
        level_d = level_q;
        if (!ownOeN) begin        // Own drive wins
            level_d = ownOut;
        end else if (keepEn) begin
            level_d = pinIn;      // Follow outside driver
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            level_q <= RST_LEVEL;
        end else begin
            level_q <= level_d;
        end
    end

    assign keepLevel = level_q;

    // ****************************************
    // Checks
    // ****************************************
    keepDrive_a : assert property (@(posedge clk_sys) disable iff (!rstn)
        !ownOeN |=> keepLevel == $past(ownOut))
        else $error("keeper lost own driven level");
endmodule
`default_nettype wire

//--- verilog/ebsc_sdram_cmd.sv
/*
 * SDRAM command encoder: turns a command code into registered strobes.
 * Assumes commands arrive as single-cycle pulses from the strobe control.
 */
`default_nettype none
module ebsc_sdram_cmd (
    input  wire logic clk_sys,
    input  wire logic rstn,
    ebsc_sdram_if.enc sd          // Command in, strobes out
);
    logic [2:0] pins_q;           // {ras,cas,we}
    logic [2:0] pins_d;
    logic       sel_q;
    logic       sel_d;
    logic       ten_q;
    logic       ten_d;

    // ****************************************
    // Command truth table
    // ****************************************
    always_comb begin
        pins_d = ebsc_pkg::SD_PINS_NOP;
        sel_d  = 1'b1;            // Deselect when idle
        ten_d  = 1'b0;
        if (sd.cmdValid) begin
            sel_d = 1'b0;
            ten_d = sd.addrTen;
            case (sd.cmd)
                ebsc_pkg::EBSC_SD_ACT: pins_d = ebsc_pkg::SD_PINS_ACT;
                ebsc_pkg::EBSC_SD_RD:  pins_d = ebsc_pkg::SD_PINS_RD;
                ebsc_pkg::EBSC_SD_WR:  pins_d = ebsc_pkg::SD_PINS_WR;
                ebsc_pkg::EBSC_SD_PRE: pins_d = ebsc_pkg::SD_PINS_PRE;
                ebsc_pkg::EBSC_SD_REF: pins_d = ebsc_pkg::SD_PINS_REF;
                ebsc_pkg::EBSC_SD_MRS: pins_d = ebsc_pkg::SD_PINS_MRS;
                default: begin
                    pins_d = ebsc_pkg::SD_PINS_NOP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pins_q <= ebsc_pkg::SD_PINS_NOP;
            sel_q  <= 1'b1;
            ten_q  <= 1'b0;
        end else begin
            pins_q <= pins_d;
            sel_q  <= sel_d;
            ten_q  <= ten_d;
        end
    end

    // Strobes together with select define the operation
    assign sd.rowStrobeN   = pins_q[2];
    assign sd.colStrobeN   = pins_q[1];
    assign sd.writeEnableN = pins_q[0];
    assign sd.selectN      = sel_q;
    assign sd.bitTen       = ten_q;

    // ****************************************
    // Checks
    // ****************************************
    sdRead_a : assert property (@(posedge clk_sys) disable iff (!rstn)
        sd.cmdValid && sd.cmd == ebsc_pkg::EBSC_SD_RD
        |=> sd.rowStrobeN && !sd.colStrobeN && sd.writeEnableN && !sd.selectN)
        else $error("SDRAM read encoded wrongly");
    sdRefresh_a : assert property (@(posedge clk_sys) disable iff (!rstn)
        sd.cmdValid && sd.cmd == ebsc_pkg::EBSC_SD_REF
        |=> !sd.rowStrobeN && !sd.colStrobeN && sd.writeEnableN)
        else $error("SDRAM refresh encoded wrongly");
endmodule
`default_nettype wire

//--- verilog/ebsc_strobe_ctrl.sv
/*
 * External bus strobe control: read and write strobes, burst indicator,
 * acknowledge wait states, suspend and three-state, SDRAM command strobes.
 * Assumes all pin inputs are synchronous to clk_sys, that bus mastership
 * comes from the arbitration logic, and that address, data and memory
 * selects are handled alongside. Pin enables are low while driving.
 */
// Overview of operation
// - Read strobe asserted on own external reads
// - Only the bus master drives read strobe
// - Write strobe asserted on own external writes
// - Only the bus master drives write strobe
// - Burst indicator marks consecutive-address transfers
// - Burst high after first access, low last
// - Master may burst-read peer port buffers
// - Burst pin keeper enabled for identity 00x
// - Low acknowledge stretches our own access
// - We pull acknowledge low for register waits
// - Suspend sampled low floats outputs next cycle; here the ack drive does not float
// - Access during suspend halts until released
// - SDRAM operation from strobes, select, bit ten
// - Strobe, burst and SDRAM pins float when suspended or bus slave
`default_nettype none
module ebsc_strobe_ctrl (
    input  wire logic                       clk_sys,
    input  wire logic                       rstn,
    // Core side access request
    input  wire logic                       reqValid,
    input  wire logic                       reqWrite,
    input  wire logic [ebsc_pkg::LEN_W-1:0] reqLen,
    output logic                            reqReady,
    output logic                            doneP,
    input  wire logic                       busMaster,
    input  wire logic [ebsc_pkg::ID_W-1:0]  processorIdentityInputs,
    // Own register space, slave side
    input  wire logic                       iopBusy,
    output logic                            iopReadP,
    output logic                            iopWriteP,
    // SDRAM command request
    input  wire logic                       sdCmdValid,
    input  wire ebsc_pkg::ebsc_sdcmd_t      sdCmd,
    input  wire logic                       sdAddrTen,
    // Bus pins
    input  wire logic                       rdNIn,
    output logic                            rdNOut,
    output logic                            rdOeN,
    input  wire logic                       wrNIn,
    output logic                            wrNOut,
    output logic                            wrOeN,
    input  wire logic                       burstIndicatorIn,
    output logic                            burstIndicatorOut,
    output logic                            burstIndicatorOeN,
    output logic                            burstKeepLevel,
    input  wire logic                       ackIn,
    output logic                            ackOut,
    output logic                            ackOeN,
    input  wire logic                       suspendTristateN,
    output logic                            rowStrobeN,
    output logic                            colStrobeN,
    output logic                            sdramWriteEnableN,
    output logic                            memorySelectN,
    output logic                            sdramAddrBitTen,
    output logic                            sdramOeN
);
    // ****************************************
    // Declarations
    // ****************************************
    ebsc_pkg::ebsc_state_t     state_q, state_d;   // Access state
    logic [ebsc_pkg::LEN_W-1:0] remain_q, remain_d; // Words left
    logic                      write_q, write_d;   // Access direction
    logic                      first_q, first_d;   // First word done
    logic                      rd_q, rd_d;         // Read strobe level
    logic                      wr_q, wr_d;         // Write strobe level
    logic                      burst_q, burst_d;   // Burst indicator level
    logic                      oeN_q, oeN_d;       // Shared strobe enable
    logic                      done_q, done_d;     // Completion pulse
    logic                      slvRd_q, slvRd_d;   // Outside read active
    logic                      slvWr_q, slvWr_d;   // Outside write active
    logic                      ackOeN_q, ackOeN_d; // Own wait-state drive
    logic                      wordDone;           // Ack seen, not suspended
    logic                      keepEn;             // Keeper enable
    ebsc_sdram_if              sdIf ();

    // ****************************************
    // Access state machine
    // ****************************************
    assign reqReady = (state_q == ebsc_pkg::EBSC_IDLE) && busMaster;
    // Completion needs ack high and no suspend
    assign wordDone = ackIn && suspendTristateN;

    always_comb begin
        state_d  = state_q;
        remain_d = remain_q;
        write_d  = write_q;
        first_d  = first_q;
        done_d   = 1'b0;
        case (state_q)
            ebsc_pkg::EBSC_IDLE: begin       // Take a new access
                if (reqValid && reqReady) begin
                    state_d  = ebsc_pkg::EBSC_XFER;
                    write_d  = reqWrite;
                    first_d  = 1'b0;
                    // Zero length taken as one word
                    remain_d = (reqLen == ebsc_pkg::LEN_ZERO) ?
                               ebsc_pkg::LEN_ONE : reqLen;
                end
            end
            ebsc_pkg::EBSC_XFER: begin       // Strobe out
                if (!suspendTristateN) begin
                    state_d = ebsc_pkg::EBSC_HALT;
                end else if (wordDone) begin
                    if (remain_q == ebsc_pkg::LEN_ONE) begin
                        state_d = ebsc_pkg::EBSC_IDLE;
                        done_d  = 1'b1;
                    end else begin
                        remain_d = remain_q - ebsc_pkg::LEN_ONE;
                        first_d  = 1'b1;
                    end
                end
            end
            ebsc_pkg::EBSC_HALT: begin       // Wait for suspend release
                if (suspendTristateN) begin
                    state_d = ebsc_pkg::EBSC_XFER;
                end
            end
            default: begin
                state_d = ebsc_pkg::EBSC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_q  <= ebsc_pkg::EBSC_IDLE;
            remain_q <= ebsc_pkg::LEN_ZERO;
            write_q  <= 1'b0;
            first_q  <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            remain_q <= remain_d;
            write_q  <= write_d;
            first_q  <= first_d;
            done_q   <= done_d;
        end
    end

    assign doneP = done_q;

    // ****************************************
    // Strobe and burst pin levels
    // ****************************************
    always_comb begin
        rd_d    = ebsc_pkg::STROBE_IDLE;
        wr_d    = ebsc_pkg::STROBE_IDLE;
        burst_d = ebsc_pkg::BURST_IDLE;
        if (state_d == ebsc_pkg::EBSC_XFER) begin
            rd_d    = write_d;
            wr_d    = !write_d;
            // High after first word, low on the last request
            burst_d = first_d && (remain_d != ebsc_pkg::LEN_ONE);
        end
        // Drive only as master and not suspended
        oeN_d = !(busMaster && suspendTristateN);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rd_q    <= ebsc_pkg::STROBE_IDLE;
            wr_q    <= ebsc_pkg::STROBE_IDLE;
            burst_q <= ebsc_pkg::BURST_IDLE;
            oeN_q   <= ebsc_pkg::OE_OFF;
        end else begin
            rd_q    <= rd_d;
            wr_q    <= wr_d;
            burst_q <= burst_d;
            oeN_q   <= oeN_d;
        end
    end

    assign rdNOut            = rd_q;
    assign wrNOut            = wr_q;
    assign burstIndicatorOut = burst_q;
    assign rdOeN             = oeN_q;
    assign wrOeN             = oeN_q;
    assign burstIndicatorOeN = oeN_q;
    assign sdramOeN          = oeN_q;

    // ****************************************
    // Slave side: outside access to our registers
    // ****************************************
    always_comb begin
        // Strobes from outside count only while we are slave
        slvRd_d  = !busMaster && !rdNIn;
        slvWr_d  = !busMaster && !wrNIn;
        // Hold ack low while an outside strobe finds the register space busy
        ackOeN_d = !((slvRd_d || slvWr_d) && iopBusy);
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            slvRd_q  <= 1'b0;
            slvWr_q  <= 1'b0;
            ackOeN_q <= ebsc_pkg::OE_OFF;
        end else begin
            slvRd_q  <= slvRd_d;
            slvWr_q  <= slvWr_d;
            ackOeN_q <= ackOeN_d;
        end
    end

    assign iopReadP  = slvRd_d && !slvRd_q;
    assign iopWriteP = slvWr_d && !slvWr_q;
    assign ackOut    = 1'b0;
    assign ackOeN    = ackOeN_q;

    // ****************************************
    // Burst pin hold circuit and SDRAM encoder
    // ****************************************
    assign keepEn = (processorIdentityInputs & ebsc_pkg::ID_KEEP_MASK)
                    == ebsc_pkg::ID_KEEP_VAL;

    ebsc_keeper #(.RST_LEVEL(ebsc_pkg::BURST_IDLE)) uBurstKeep (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .keepEn    (keepEn),
        .pinIn     (burstIndicatorIn),
        .ownOeN    (oeN_q),
        .ownOut    (burst_q),
        .keepLevel (burstKeepLevel)
    );

    assign sdIf.cmdValid = sdCmdValid && busMaster;
    assign sdIf.cmd      = sdCmd;
    assign sdIf.addrTen  = sdAddrTen;

    ebsc_sdram_cmd uSdram (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .sd      (sdIf.enc)
    );

    assign rowStrobeN        = sdIf.rowStrobeN;
    assign colStrobeN        = sdIf.colStrobeN;
    assign sdramWriteEnableN = sdIf.writeEnableN;
    assign memorySelectN     = sdIf.selectN;
    assign sdramAddrBitTen   = sdIf.bitTen;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    readMaster_a : assert property (!rdOeN |-> $past(busMaster))
        else $error("read strobe driven while not master");
    writeMaster_a : assert property (!wrOeN |-> $past(busMaster))
        else $error("write strobe driven while not master");
    suspendFloat_a : assert property (!suspendTristateN |=> rdOeN && wrOeN
        && burstIndicatorOeN && sdramOeN)
        else $error("outputs not floated after suspend");
    haltHold_a : assert property (state_q != ebsc_pkg::EBSC_IDLE
        && !suspendTristateN |=> !doneP ##0 state_q == ebsc_pkg::EBSC_HALT)
        else $error("access completed during suspend");
    ackStretch_a : assert property (state_q == ebsc_pkg::EBSC_XFER && !ackIn
        |=> state_q != ebsc_pkg::EBSC_IDLE && !doneP)
        else $error("access ended with ack low");
    readStrobe_a : assert property (state_q == ebsc_pkg::EBSC_XFER && !write_q
        |-> !rdNOut && wrNOut)
        else $error("read strobe missing");
    writeStrobe_a : assert property (state_q == ebsc_pkg::EBSC_XFER && write_q
        |-> !wrNOut && rdNOut)
        else $error("write strobe missing");
    burstLast_a : assert property (state_q == ebsc_pkg::EBSC_XFER
        && remain_q == ebsc_pkg::LEN_ONE |-> !burstIndicatorOut)
        else $error("burst high on last request");
    burstMid_a : assert property (state_q == ebsc_pkg::EBSC_XFER && first_q
        && remain_q != ebsc_pkg::LEN_ONE |-> burstIndicatorOut)
        else $error("burst low inside a burst");
    ackDrive_a : assert property (!busMaster && !rdNIn && iopBusy
        |=> !ackOeN && !ackOut)
        else $error("ack not pulled low for wait");

    burstRun_c : cover property (burstIndicatorOut ##1 !burstIndicatorOut ##[1:4] doneP);
    haltResume_c : cover property (state_q == ebsc_pkg::EBSC_HALT
        ##1 state_q == ebsc_pkg::EBSC_XFER);
    slaveWait_c : cover property (!ackOeN [*2] ##1 ackOeN);
endmodule
`default_nettype wire
